// [logic/iaes_pkg.sv]
`default_nettype none
package iaes_pkg;
	// ----------------------------------------------------------------
	// management register offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_XOVER = 5'h15; // crossover_select
	localparam logic [4:0] REG_CTRL = 5'h16; // indirect_control
	localparam logic [4:0] REG_DATA = 5'h1d; // indirect_data
	localparam logic [4:0] REG_PTR = 5'h1e; // indirect_pointer
	// ----------------------------------------------------------------
	// expanded memory locations
	// ----------------------------------------------------------------
	localparam logic [15:0] EXP_STAT_LO = 16'h810d; // event_status_low
	localparam logic [15:0] EXP_STAT_HI = 16'h810e; // event_status_high
	localparam logic [15:0] EXP_EN_LO = 16'h8113; // event_enable_low
	localparam logic [15:0] EXP_EN_HI = 16'h8114; // event_enable_high
	localparam logic [15:0] EXP_CLR_LO = 16'h8115; // event_clear_low
	localparam logic [15:0] EXP_CLR_HI = 16'h8116; // event_clear_high
	// ----------------------------------------------------------------
	// reset values and fields
	// ----------------------------------------------------------------
	localparam logic [15:0] XOVER_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST = 16'h000b; // retime on, access off, width 11
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [7:0] EN_RST = 8'h00;
	localparam logic [7:0] EN_HI_MASK = 8'h7f; // top enable bit reserved
	localparam int CTRL_RETIME_BIT = 3;
	localparam int CTRL_ACC_BIT = 2;
	localparam logic [1:0] WIDTH_8 = 2'h1;
	localparam logic [1:0] WIDTH_16 = 2'h2;
	localparam logic [15:0] STAT_RST = 16'h0100; // high bit 0 resets to 1
	localparam int HI_FW_ROM = 10; // flat index of high bit 2
	localparam int HI_FW_RAM = 9; // flat index of high bit 1
	// ----------------------------------------------------------------
	// management frame
	// ----------------------------------------------------------------
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [5:0] HDR_LAST = 6'h0c; // 13 header bits after first start bit
	localparam logic [5:0] WR_LAST = 6'h11; // 2 turnaround + 16 data
	localparam logic [5:0] RD_LAST = 6'h11; // release slot after last data bit
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] OP_WR = 2'h1;
	typedef enum logic [1:0] {
		ST_PRE = 2'b00,
		ST_HDR = 2'b01,
		ST_RD = 2'b10,
		ST_WR = 2'b11
	} iaes_state_e;
endpackage
`default_nettype wire

// [logic/iaes_evt_bit.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// one sticky event flag
// ------------------------------------------------------------------
module iaes_evt_bit import iaes_pkg::*; #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic set_in,
	input wire logic clr_in,
	output logic flag_q
);
	// set beats a clear in the same cycle so no event is lost
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flag_q <= RST_VAL;
		end else if (set_in) begin
			flag_q <= 1'b1;
		end else if (clr_in) begin
			flag_q <= 1'b0;
		end
	end
endmodule // iaes_evt_bit
`default_nettype wire

// [logic/iaes_top.sv]
// Function
// (RULE1) manual crossover bit swaps pairs A/B
// (RULE2) control bit 3 retimes outgoing data, resets 1
// (RULE3) control bit 2 enables indirect access, resets 0
// (RULE4) width field: 01 byte, 10 word, resets 11
// (RULE5) data register carries memory value, byte in low
// (RULE6) pointer register holds 16-bit memory address
// (RULE7) status bytes at 0x810D/0x810E, indirect only
// (RULE8) low bit 7: negotiation count over limit
// (RULE9) low bit 6: negotiation complete changed
// (RULE10) low bit 5: remote fault changed
// (RULE11) low bit 4: speed changed while linked
// (RULE12) low bit 3: link session sum over limit
// (RULE13) low bit 2: link status changed
// (RULE14) low bit 1: duplex changed while linked
// (RULE15) low bit 0: jabber changed
// (RULE16) low bits reset 0, clear via clear byte
// (RULE17) high bit 7: config fault changed
// (RULE18) high bit 6: master resolution changed while linked
// (RULE19) high bits 5/4: local/remote receiver changed
// (RULE20) high bit 3: idle errors over limit
// (RULE21) high bits 2/1: firmware in ROM/RAM
// (RULE22) high bit 0: firmware reset, resets 1
// (RULE23) low enable bits gate interrupt, reset 0
// (RULE24) event bits sticky until cleared
// (RULE25) interrupt when any enabled event set
`timescale 1ns/1ps
`default_nettype none
module iaes_top import iaes_pkg::*; #(
	parameter int CNT_W = 8
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out_q,
	output logic mdio_oe_q,
	input wire logic [4:0] phy_addr,
	input wire logic auto_xover_en,
	input wire logic auto_pair_swap,
	output logic pair_swap_q,
	input wire logic an_complete,
	input wire logic an_remote_fault,
	input wire logic [1:0] resolved_speed,
	input wire logic link_up,
	input wire logic duplex_full,
	input wire logic jabber,
	input wire logic [CNT_W-1:0] negotiation_occurrence_count,
	input wire logic [CNT_W-1:0] negotiation_count_limit,
	input wire logic [CNT_W-1:0] link_count_10,
	input wire logic [CNT_W-1:0] link_count_100,
	input wire logic [CNT_W-1:0] link_count_1000,
	input wire logic [CNT_W+1:0] link_count_limit,
	input wire logic config_fault,
	input wire logic resolved_master,
	input wire logic local_rcvr_ok,
	input wire logic remote_rcvr_ok,
	input wire logic [7:0] idle_error_count,
	input wire logic [7:0] idle_error_limit,
	input wire logic fw_in_rom,
	input wire logic fw_reset_seq,
	output logic event_irq_q
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic mdc_q; // management clock seen last cycle
	logic mdc_rise; // sample point of the frame
	logic mdc_fall; // launch point when not retimed
	iaes_state_e state_q; // frame parser state
	logic [5:0] cnt_q; // bit counter within a phase
	logic [12:0] hdr_q; // start, op, phy, reg bits
	logic [12:0] hdr_d;
	logic [15:0] sh_q; // read or write data shifter
	logic [15:0] xover_q; // crossover_select
	logic [15:0] ctrl_q; // indirect_control
	logic [15:0] data_q; // indirect_data
	logic [15:0] ptr_q; // indirect_pointer
	logic [15:0] ptr_nx; // second byte of a word access
	logic [7:0] en_lo_q; // event_enable_low
	logic [7:0] en_hi_q; // event_enable_high
	logic [15:0] stat_w; // {high, low} status bytes
	logic [15:0] set_v; // raw event strobes
	logic [15:0] clr_v; // clear strobes from the clear bytes
	logic [10:0] src_d; // level sources for change detection
	logic [10:0] src_q;
	logic [CNT_W+1:0] link_sum; // total link sessions
	logic acc_ok; // indirect access enabled with legal width
	logic wide; // word access
	logic rd_take; // read header accepted
	logic reg_wr; // write frame complete
	logic [4:0] wr_addr;
	logic [15:0] wr_word;
	logic mem_wr; // data write reaches expanded memory
	logic [15:0] ind_rd; // indirect read value
	logic [15:0] rd_word; // register value for a read frame
	logic pend_oe_q; // next slot drive, waiting for a fall
	logic pend_out_q;
	logic drv_oe_d;
	logic drv_out_d;
	logic retime;

	// ----------------------------------------------------------------
	// management clock edges
	// ----------------------------------------------------------------
	// inputs are synchronous to ref_clk, so a plain delay gives edges
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mdc_q <= 1'b0;
		end else begin
			mdc_q <= mdc;
		end
	end
	assign mdc_rise = mdc & ~mdc_q;
	assign mdc_fall = ~mdc & mdc_q;

	// ----------------------------------------------------------------
	// frame parser
	// ----------------------------------------------------------------
	assign hdr_d = {hdr_q[11:0], mdio_in};
	assign rd_take = mdc_rise && state_q == ST_HDR && cnt_q == HDR_LAST && hdr_d[12]
		&& hdr_d[11:10] == OP_RD && hdr_d[9:5] == phy_addr;
	assign reg_wr = mdc_rise && state_q == ST_WR && cnt_q == WR_LAST;
	assign wr_addr = hdr_q[4:0];
	assign wr_word = {sh_q[14:0], mdio_in};

	// state, counter and shifters advance only on a rising mdc
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q <= ST_PRE;
			cnt_q <= 6'h00;
			hdr_q <= 13'h0000;
			sh_q <= 16'h0000;
		end else if (mdc_rise) begin
			case (state_q)
				ST_PRE: begin
					// count ones; a zero after a full preamble opens a frame
					if (mdio_in) begin
						cnt_q <= (cnt_q == PREAMBLE_LEN) ? cnt_q : cnt_q + 6'h01;
					end else if (cnt_q == PREAMBLE_LEN) begin
						state_q <= ST_HDR;
						cnt_q <= 6'h00;
					end else begin
						cnt_q <= 6'h00;
					end
				end
				ST_HDR: begin
					hdr_q <= hdr_d;
					if (cnt_q != HDR_LAST) begin
						cnt_q <= cnt_q + 6'h01;
					end else if (rd_take) begin
						state_q <= ST_RD;
						cnt_q <= 6'h00;
						sh_q <= rd_word;
					end else if (hdr_d[12] && hdr_d[11:10] == OP_WR
						&& hdr_d[9:5] == phy_addr) begin
						state_q <= ST_WR;
						cnt_q <= 6'h00;
					end else begin
						// other address or bad opcode: wait for a new preamble
						state_q <= ST_PRE;
						cnt_q <= 6'h00;
					end
				end
				ST_RD: begin
					// shift only after a data bit has been launched
					if (cnt_q != 6'h00) begin
						sh_q <= {sh_q[14:0], 1'b0};
					end
					if (cnt_q == RD_LAST) begin
						state_q <= ST_PRE;
						cnt_q <= 6'h00;
					end else begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
				ST_WR: begin
					sh_q <= wr_word;
					if (cnt_q == WR_LAST) begin
						state_q <= ST_PRE;
						cnt_q <= 6'h00;
					end else begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
				default: begin
					state_q <= ST_PRE;
					cnt_q <= 6'h00;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// outgoing management data
	// ----------------------------------------------------------------
	// value for the slot that starts after this rising edge
	always_comb begin
		drv_oe_d = 1'b0;
		drv_out_d = 1'b0;
		if (state_q == ST_RD) begin
			if (cnt_q == 6'h00) begin
				drv_oe_d = 1'b1; // second turnaround bit driven low
			end else if (cnt_q != RD_LAST) begin
				drv_oe_d = 1'b1;
				drv_out_d = sh_q[15];
			end
		end
	end
	assign retime = ctrl_q[CTRL_RETIME_BIT];

	// retimed data changes on the rising mdc; otherwise it waits for
	// the fall, which gives more hold but less setup at slow mdc
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pend_oe_q <= 1'b0;
			pend_out_q <= 1'b0;
			mdio_oe_q <= 1'b0;
			mdio_out_q <= 1'b0;
		end else begin
			if (mdc_rise) begin
				pend_oe_q <= drv_oe_d;
				pend_out_q <= drv_out_d;
			end
			if (mdc_rise && retime) begin // RULE2
				mdio_oe_q <= drv_oe_d;
				mdio_out_q <= drv_out_d;
			end else if (mdc_fall && !retime) begin // RULE2
				mdio_oe_q <= pend_oe_q;
				mdio_out_q <= pend_out_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// expanded memory access
	// ----------------------------------------------------------------
	assign wide = ctrl_q[1:0] == WIDTH_16; // RULE4
	assign acc_ok = ctrl_q[CTRL_ACC_BIT]
		&& (ctrl_q[1:0] == WIDTH_8 || wide); // RULE3 RULE4
	assign ptr_nx = ptr_q + 16'h0001;
	assign mem_wr = reg_wr && wr_addr == REG_DATA && acc_ok;

	// one expanded memory byte; clear bytes read back as zero
	function automatic logic [7:0] mem_rd8(input logic [15:0] a);
		case (a)
			EXP_STAT_LO: mem_rd8 = stat_w[7:0]; // RULE7
			EXP_STAT_HI: mem_rd8 = stat_w[15:8]; // RULE7
			EXP_EN_LO: mem_rd8 = en_lo_q;
			EXP_EN_HI: mem_rd8 = en_hi_q;
			default: mem_rd8 = 8'h00;
		endcase
	endfunction

	// byte written to location a, or none
	function automatic logic mem_hit(input logic [15:0] a);
		mem_hit = mem_wr && (ptr_q == a || (wide && ptr_nx == a));
	endfunction

	function automatic logic [7:0] mem_byte(input logic [15:0] a);
		mem_byte = (ptr_q == a) ? wr_word[7:0] : wr_word[15:8];
	endfunction

	// byte mode leaves the upper octet zero; a process, not an assign,
	// so that status and enable changes seen inside the function wake it
	always_comb begin
		ind_rd = wide ? {mem_rd8(ptr_nx), mem_rd8(ptr_q)}
			: {8'h00, mem_rd8(ptr_q)}; // RULE5 RULE6
	end

	// ----------------------------------------------------------------
	// management registers
	// ----------------------------------------------------------------
	always_comb begin
		case (hdr_d[4:0])
			REG_XOVER: rd_word = xover_q;
			REG_CTRL: rd_word = ctrl_q;
			REG_DATA: rd_word = acc_ok ? ind_rd : data_q; // RULE5
			REG_PTR: rd_word = ptr_q;
			default: rd_word = 16'h0000;
		endcase
	end

	// control, crossover and pointer are plain read/write words
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			xover_q <= XOVER_RST;
			ctrl_q <= CTRL_RST; // RULE2 RULE3 RULE4
			ptr_q <= PTR_RST;
		end else if (reg_wr) begin
			case (wr_addr)
				REG_XOVER: xover_q <= wr_word;
				REG_CTRL: ctrl_q <= wr_word;
				REG_PTR: ptr_q <= wr_word; // RULE6
				default: ;
			endcase
		end
	end

	// data word holds the last value written or fetched
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			data_q <= DATA_RST;
		end else if (reg_wr && wr_addr == REG_DATA) begin
			data_q <= wr_word; // RULE5
		end else if (rd_take && hdr_d[4:0] == REG_DATA && acc_ok) begin
			data_q <= ind_rd; // RULE5
		end
	end

	// enable bytes live in expanded memory
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			en_lo_q <= EN_RST; // RULE23
			en_hi_q <= EN_RST;
		end else begin
			if (mem_hit(EXP_EN_LO)) begin
				en_lo_q <= mem_byte(EXP_EN_LO); // RULE23
			end
			if (mem_hit(EXP_EN_HI)) begin
				en_hi_q <= mem_byte(EXP_EN_HI) & EN_HI_MASK;
			end
		end
	end

	// manual swap only counts while automatic selection is off
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pair_swap_q <= 1'b0;
		end else begin
			pair_swap_q <= auto_xover_en ? auto_pair_swap : xover_q[0]; // RULE1
		end
	end

	// ----------------------------------------------------------------
	// event sources
	// ----------------------------------------------------------------
	assign src_d = {an_complete, an_remote_fault, resolved_speed, link_up, duplex_full,
		jabber, config_fault, resolved_master, local_rcvr_ok, remote_rcvr_ok};

	// loading during reset too keeps the release from looking like a change
	always_ff @(posedge ref_clk) begin
		src_q <= src_d;
	end

	assign link_sum = {2'b00, link_count_10} + {2'b00, link_count_100}
		+ {2'b00, link_count_1000};

	// qualified changes need link up before and after
	always_comb begin
		set_v = 16'h0000;
		set_v[7] = negotiation_occurrence_count > negotiation_count_limit; // RULE8
		set_v[6] = src_d[10] ^ src_q[10]; // RULE9
		set_v[5] = src_d[9] ^ src_q[9]; // RULE10
		set_v[4] = link_up && src_q[6] && src_d[8:7] != src_q[8:7]; // RULE11
		set_v[3] = link_sum > link_count_limit; // RULE12
		set_v[2] = src_d[6] ^ src_q[6]; // RULE13
		set_v[1] = link_up && src_q[6] && (src_d[5] ^ src_q[5]); // RULE14
		set_v[0] = src_d[4] ^ src_q[4]; // RULE15
		set_v[15] = src_d[3] ^ src_q[3]; // RULE17
		set_v[14] = link_up && src_q[6] && (src_d[2] ^ src_q[2]); // RULE18
		set_v[13] = src_d[1] ^ src_q[1]; // RULE19
		set_v[12] = src_d[0] ^ src_q[0]; // RULE19
		set_v[11] = idle_error_count > idle_error_limit; // RULE20
		set_v[8] = fw_reset_seq; // RULE22
	end

	// clear bytes act as one-cycle strobes and store nothing
	always_comb begin
		clr_v = {mem_hit(EXP_CLR_HI) ? mem_byte(EXP_CLR_HI) : 8'h00,
			mem_hit(EXP_CLR_LO) ? mem_byte(EXP_CLR_LO) : 8'h00}; // RULE16
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 16; i++) begin : g_evt
		if (i == HI_FW_ROM || i == HI_FW_RAM) begin : g_fw
			// firmware location is a live indication, not an event
			logic fw_q;
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					fw_q <= 1'b0;
				end else begin
					fw_q <= (i == HI_FW_ROM) ? fw_in_rom : ~fw_in_rom; // RULE21
				end
			end
			assign stat_w[i] = fw_q;
		end else begin : g_flag
			iaes_evt_bit #(
				.RST_VAL(STAT_RST[i])
			) u_bit (
				.ref_clk(ref_clk),
				.srst(srst),
				.set_in(set_v[i]),
				.clr_in(clr_v[i]),
				.flag_q(stat_w[i])
			); // RULE16 RULE22 RULE24
		end
	end

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			event_irq_q <= 1'b0;
		end else begin
			event_irq_q <= |(stat_w & {en_hi_q, en_lo_q}); // RULE23 RULE25
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	swap_manual_a: // RULE1
	assert property (@(posedge ref_clk) disable iff (srst)
		!auto_xover_en |=> pair_swap_q == $past(xover_q[0]))
		else $error("manual swap not following crossover bit");
	ctrl_reset_a: // RULE3
	assert property (@(posedge ref_clk) srst |=> ctrl_q == CTRL_RST && !acc_ok)
		else $error("control word wrong after reset");
	retime_launch_a: // RULE2
	assert property (@(posedge ref_clk) disable iff (srst)
		mdc_rise && retime && !$past(srst) |=> mdio_oe_q == $past(drv_oe_d)
		&& mdio_out_q == $past(drv_out_d))
		else $error("retimed data not launched on rising mdc");
	access_off_a: // RULE3
	assert property (@(posedge ref_clk) disable iff (srst)
		reg_wr && wr_addr == REG_DATA && !ctrl_q[CTRL_ACC_BIT]
		|=> en_lo_q == $past(en_lo_q) && stat_w[7:0] == $past(stat_w[7:0] | set_v[7:0]))
		else $error("memory changed with indirect access off");
	link_event_a: // RULE13
	assert property (@(posedge ref_clk) disable iff (srst)
		link_up != $past(link_up) && !$past(srst) |-> ##1 stat_w[2][*2])
		else $error("link change not latched");
	sticky_low_a: // RULE24
	assert property (@(posedge ref_clk) disable iff (srst)
		stat_w[6] && !clr_v[6] |=> stat_w[6])
		else $error("event flag dropped without a clear");
	clear_low_a: // RULE16
	assert property (@(posedge ref_clk) disable iff (srst)
		clr_v[5] && !set_v[5] |=> !stat_w[5])
		else $error("clear strobe did not clear flag");
	irq_level_a: // RULE25
	assert property (@(posedge ref_clk) disable iff (srst)
		##1 event_irq_q == $past(|(stat_w & {en_hi_q, en_lo_q})))
		else $error("interrupt not matching enabled events");
	fw_flags_a: // RULE21
	assert property (@(posedge ref_clk) disable iff (srst)
		!$past(srst) |-> stat_w[HI_FW_ROM] != stat_w[HI_FW_RAM])
		else $error("firmware location bits not complementary");
	fw_reset_a: // RULE22
	assert property (@(posedge ref_clk) srst |=> stat_w[8] && stat_w[7:0] == 8'h00)
		else $error("status bytes wrong after reset");
	read_turn_a: // RULE7
	assert property (@(posedge ref_clk) disable iff (srst)
		rd_take |=> state_q == ST_RD && sh_q == $past(rd_word))
		else $error("read frame did not load register value");
endmodule // iaes_top
`default_nettype wire

// [testbench/iaes_sta_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// management station: mdc stands still between frames
// ----------------------------------------------------------------
module iaes_sta_model import iaes_pkg::*; (
	input wire logic ref_clk,
	input wire logic mdio_wire,
	input wire logic [4:0] phy_addr,
	output logic mdc,
	output logic sta_out,
	output logic sta_oe
);
	logic smp; // line level seen half a clock after mdc rises
	initial begin
		mdc = 1'b0;
		sta_out = 1'b1;
		sta_oe = 1'b0;
	end
	// one slot: low 2 clocks, high 2; sample after either launch point
	task automatic slot(input logic b, input logic drv);
		@(posedge ref_clk);
		mdc <= 1'b0;
		sta_out <= b;
		sta_oe <= drv;
		repeat (2) @(posedge ref_clk);
		mdc <= 1'b1;
		@(negedge ref_clk);
		smp = mdio_wire;
		@(posedge ref_clk);
	endtask
	// whole frame, msb first; reads let go from the first turnaround
	task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [13:0] hdr;
		hdr = {2'b01, op, phy_addr, ra};
		repeat (32) slot(1'b1, 1'b1);
		for (int i = 13; i >= 0; i--) slot(hdr[i], 1'b1);
		slot(1'b1, op == OP_WR);
		slot(1'b0, op == OP_WR);
		for (int i = 15; i >= 0; i--) begin
			slot(wd[i], op == OP_WR);
			rd[i] = smp;
		end
		@(posedge ref_clk);
		mdc <= 1'b0;
		sta_oe <= 1'b0;
	endtask
endmodule // iaes_sta_model
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench import iaes_pkg::*;;
	logic ref_clk = 1'b0, srst = 1'b1, mdc, mdio_out_q, mdio_oe_q, sta_out, sta_oe;
	logic auto_xover_en, auto_pair_swap, pair_swap_q, event_irq_q, an_complete;
	logic an_remote_fault, link_up, duplex_full, jabber, config_fault, resolved_master;
	logic local_rcvr_ok, remote_rcvr_ok, fw_in_rom, fw_reset_seq;
	logic [1:0] resolved_speed;
	logic [4:0] phy_addr;
	logic [7:0] negotiation_occurrence_count, negotiation_count_limit, link_count_10;
	logic [7:0] link_count_100, link_count_1000, idle_error_count, idle_error_limit, v;
	logic [9:0] link_count_limit;
	logic [7:0] lfsr = 8'h4e; // random source, fixed start
	logic [15:0] rv;
	int err_count = 0, cmp_count = 0, cyc = 0;
	// pulled-up line: released by both parties reads high
	wire logic mdio_in = mdio_oe_q ? mdio_out_q : (sta_oe ? sta_out : 1'b1);
	iaes_top dut (.ref_clk, .srst, .mdc, .mdio_in, .mdio_out_q, .mdio_oe_q, .phy_addr,
		.auto_xover_en, .auto_pair_swap, .pair_swap_q, .an_complete, .an_remote_fault,
		.resolved_speed, .link_up, .duplex_full, .jabber, .negotiation_occurrence_count,
		.negotiation_count_limit, .link_count_10, .link_count_100, .link_count_1000,
		.link_count_limit, .config_fault, .resolved_master, .local_rcvr_ok, .remote_rcvr_ok,
		.idle_error_count, .idle_error_limit, .fw_in_rom, .fw_reset_seq, .event_irq_q);
	iaes_sta_model sta (.ref_clk, .mdio_wire(mdio_in), .phy_addr, .mdc, .sta_out, .sta_oe);
	always #25 ref_clk = ~ref_clk;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction
	function automatic logic [15:0] ev(input int i);
		return 16'h0001 << i;
	endfunction
	// firmware location pair is always shown in the high byte
	function automatic logic [15:0] fw_bits();
		return fw_in_rom ? 16'h0004 : 16'h0002;
	endfunction
	task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		sta.frame(OP_WR, ra, d, rv);
	endtask
	task automatic rd(input logic [4:0] ra, output logic [15:0] d);
		sta.frame(OP_RD, ra, 16'h0000, d);
	endtask
	task automatic mw(input logic [15:0] a, input logic [15:0] d);
		wr(REG_PTR, a);
		wr(REG_DATA, d);
	endtask
	task automatic mck(input string nm, input logic [15:0] a, input logic [15:0] exp);
		wr(REG_PTR, a);
		rd(REG_DATA, rv);
		check(nm, rv, exp);
	endtask
	// drive one event source, then put thresholds back under their limits
	task automatic fire(input logic hi, input int i);
		@(posedge ref_clk);
		if (hi) begin
			case (i)
				7: config_fault <= ~config_fault;
				6: resolved_master <= ~resolved_master;
				5: local_rcvr_ok <= ~local_rcvr_ok;
				4: remote_rcvr_ok <= ~remote_rcvr_ok;
				default: idle_error_count <= idle_error_limit + 8'h01;
			endcase
		end else begin
			case (i)
				7: negotiation_occurrence_count <= negotiation_count_limit + 8'h01;
				6: an_complete <= ~an_complete;
				5: an_remote_fault <= ~an_remote_fault;
				4: resolved_speed <= resolved_speed + 2'h1;
				3: link_count_limit <= link_count_10 + link_count_100 + link_count_1000 - 10'h001;
				2: link_up <= 1'b0;
				1: duplex_full <= ~duplex_full;
				default: jabber <= ~jabber;
			endcase
		end
		repeat (2) @(posedge ref_clk);
		negotiation_occurrence_count <= 8'h00;
		idle_error_count <= 8'h00;
		link_count_limit <= 10'h3ff;
		link_up <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic stop_test();
		$display("counts: err %0d cmp %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard, well above the expected run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			stop_test();
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{auto_xover_en, auto_pair_swap, an_complete, an_remote_fault, duplex_full} = '0;
		{jabber, config_fault, resolved_master, local_rcvr_ok, remote_rcvr_ok} = '0;
		{fw_reset_seq, resolved_speed, negotiation_occurrence_count, idle_error_count} = '0;
		link_up = 1'b1;
		fw_in_rom = 1'b1;
		phy_addr = 5'h05;
		negotiation_count_limit = rnd() >> 1;
		idle_error_limit = rnd() >> 1;
		link_count_10 = rnd() | 8'h01;
		link_count_100 = rnd();
		link_count_1000 = rnd();
		link_count_limit = 10'h3ff;
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rd(REG_CTRL, rv);
		check("ctrl", rv, 16'h000b);
		rd(REG_XOVER, rv);
		check("xover", rv, 16'h0000);
		rd(REG_PTR, rv);
		check("ptr", rv, PTR_RST);
		rd(5'h03, rv);
		check("unmapped", rv, 16'h0000);
		mck("acc_off", EXP_STAT_HI, DATA_RST);
		mw(EXP_EN_LO, 16'h00a5); // access off: only the data word takes it
		rd(REG_DATA, rv);
		check("acc_off_wr", rv, 16'h00a5);
		wr(REG_CTRL, 16'h000c); // access on, reserved width
		mw(EXP_EN_LO, 16'h00ff);
		rd(REG_DATA, rv);
		check("acc_bad_width", rv, 16'h00ff);
		check("irq_rst", event_irq_q, 16'h0000);
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			v = rnd();
			auto_xover_en <= k[0];
			auto_pair_swap <= v[1];
			wr(REG_XOVER, {8'h00, v});
			repeat (2) @(posedge ref_clk);
			check("swap", pair_swap_q, k[0] ? v[1] : v[0]);
		end
		$display("test crossover done");
		wr(REG_CTRL, 16'h000d); // controller enables byte access
		fire(1'b0, 0);
		check("irq_masked", event_irq_q, 16'h0000);
		mw(EXP_EN_LO, 16'h00ff);
		@(negedge ref_clk); // interrupt follows the enable one edge later
		check("irq_on", event_irq_q, 16'h0001);
		mw(EXP_CLR_LO, 16'h00ff);
		for (int i = 7; i >= 0; i--) begin
			fire(1'b0, i);
			mck("stat_lo", EXP_STAT_LO, ev(i));
			check("irq_lo", event_irq_q, 16'h0001);
			mw(EXP_CLR_LO, ev(i));
			mck("clr_lo", EXP_STAT_LO, 16'h0000);
			check("irq_off", event_irq_q, 16'h0000);
		end
		@(posedge ref_clk);
		link_up <= 1'b0;
		@(posedge ref_clk);
		resolved_speed <= resolved_speed + 2'h1;
		duplex_full <= ~duplex_full;
		@(posedge ref_clk);
		link_up <= 1'b1;
		mck("link_down", EXP_STAT_LO, 16'h0004);
		mw(EXP_CLR_LO, 16'h00ff);
		$display("test low events done");
		mck("hi_rst", EXP_STAT_HI, fw_bits() | 16'h0001);
		mw(EXP_CLR_HI, 16'h00ff);
		for (int i = 7; i >= 3; i--) begin
			fire(1'b1, i);
			mck("stat_hi", EXP_STAT_HI, ev(i) | fw_bits());
			check("irq_hi", event_irq_q, 16'h0000);
			mw(EXP_CLR_HI, ev(i));
			mck("clr_hi", EXP_STAT_HI, fw_bits());
		end
		@(posedge ref_clk);
		fw_in_rom <= 1'b0;
		fw_reset_seq <= 1'b1;
		@(posedge ref_clk);
		fw_reset_seq <= 1'b0;
		mck("fw", EXP_STAT_HI, 16'h0003);
		mw(EXP_CLR_HI, 16'h0001);
		mck("fw_clr", EXP_STAT_HI, 16'h0002);
		$display("test high events done");
		rv = {rnd(), rnd()};
		wr(REG_CTRL, 16'h000e);
		mw(EXP_EN_LO, rv);
		v = rv[7:0];
		mck("word", EXP_EN_LO, {rv[15:8] & EN_HI_MASK, rv[7:0]});
		wr(REG_CTRL, 16'h0005);
		mck("byte_noretime", EXP_EN_LO, {8'h00, v});
		mw(EXP_STAT_LO, 16'h00ff);
		mck("stat_ro", EXP_STAT_LO, 16'h0000);
		$display("test width done");
		stop_test();
	end
endmodule // testbench
`default_nettype wire
